// [led_mmd_id_pkg.sv]
// Constants for the LED sense control and vendor identifier registers
package led_mmd_id_pkg;

	// ------------------------------------------------------------
	// Management device addresses
	// ------------------------------------------------------------
	localparam logic [4:0]  LED_MMD_ADDR            = 5'h1E;
	localparam logic [4:0]  VENDOR_MMD_ADDR         = 5'h1F;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [15:0] LED_DRIVE_SENSE_ADDR    = 16'h8C83;
	localparam logic [15:0] VENDOR_DEV_ID_HIGH_ADDR = 16'h0002;
	localparam logic [15:0] VENDOR_DEV_ID_LOW_ADDR  = 16'h0003;
	localparam logic [15:0] DEVICES_PRESENT_LO_ADDR = 16'h0005;
	localparam logic [15:0] DEVICES_PRESENT_HI_ADDR = 16'h0006;
	localparam logic [15:0] VENDOR_DEV_STATUS_ADDR  = 16'h0008;

	// ------------------------------------------------------------
	// Reset and constant values
	// ------------------------------------------------------------
	localparam logic [15:0] LED_DRIVE_SENSE_RESET   = 16'h0000;
	localparam logic [15:0] DEVICES_PRESENT_LO_VAL  = 16'h008B;
	localparam logic [15:0] DEVICES_PRESENT_HI_VAL  = 16'hC000;
	localparam logic [15:0] VENDOR_DEV_STATUS_VAL   = 16'h8000;
	localparam logic [15:0] UNMAPPED_READ_VAL       = 16'h0000;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int          ORG_ID_LSB              = 10;
	localparam int          MODEL_LSB               = 4;
	localparam int          REVISION_LSB            = 0;
	localparam int          SENSE_SELECT_W          = 2;

	// ------------------------------------------------------------
	// Drive sense codes
	// ------------------------------------------------------------
	localparam logic [1:0]  SENSE_AUTO              = 2'h0;
	localparam logic [1:0]  SENSE_ACTIVE_HIGH       = 2'h1;
	localparam logic [1:0]  SENSE_ACTIVE_LOW        = 2'h2;

	// ------------------------------------------------------------
	// LED function codes handled here
	// ------------------------------------------------------------
	localparam logic [4:0]  FN_BLINK                = 5'h0F;
	localparam logic [4:0]  FN_HIGH_TX_LEVEL        = 5'h10;
	localparam logic [4:0]  FN_LOW_TX_LEVEL         = 5'h11;
	localparam logic [4:0]  FN_LEADER               = 5'h12;
	localparam logic [4:0]  FN_FOLLOWER             = 5'h13;
	localparam logic [4:0]  FN_LINK_CFG_MISMATCH    = 5'h14;
	localparam logic [4:0]  FN_LINK_GOOD            = 5'h15;
	localparam logic [4:0]  FN_NEGOTIATION_DONE     = 5'h16;
	localparam logic [4:0]  FN_TIMESTAMP_TIMER      = 5'h17;
	localparam logic [4:0]  FN_LOCAL_RX_OK          = 5'h18;
	localparam logic [4:0]  FN_REMOTE_RX_OK         = 5'h19;
	localparam logic [4:0]  FN_REF_CLOCK            = 5'h1A;
	localparam logic [4:0]  FN_TX_CLOCK             = 5'h1B;
	localparam logic [4:0]  FN_FAST_CLOCK           = 5'h1C;

endpackage

// [led_mmd_id_regs.sv]
// LED drive sense, upper LED function decode and vendor identifier registers
// Function
// - Codes 15 to 25 pick blink, high and low transmit level, leader, follower, mismatch, link good, negotiation done, timer, local and remote receiver status.
// - Codes 26, 27 and 28 route the reference, transmit and fast internal clocks to the LED.
// - Drive sense 0 uses the sensed polarity, 1 forces active high, 2 forces active low.
// - Polarity is sensed internally by default and the host may override it by writing the sense register.
// - The sense register lives at device 0x1E address 0x8C83 and resets to zero.
// - Identifier high at device 0x1F address 0x0002 returns a fixed 16-bit value.
// - Identifier low returns organisation bits 15:10, model 9:4 and revision 3:0.
// - Devices present low reads as the constant bitmap of the basic and standard devices.
// - Devices present high reads as the constant showing both vendor devices.
// - The status field in bits 15:14 reads binary 10, meaning a device responds.
// - The status register sits at 0x0008, reads 0x8000 and its low 14 bits read zero.
// - Blink and clock codes follow their signal whatever the link state.
// - Status indicator codes show static on while the signal is high and off while low.
`timescale 1ns/1ps
`default_nettype none

module led_mmd_id_regs #(
	parameter logic [15:0] VENDOR_ID_HIGH = 16'h5A5A, // Arbitrary value
	parameter logic [5:0]  ORG_ID_BITS    = 6'h15,    // Arbitrary value
	parameter logic [5:0]  MODEL_NUMBER   = 6'h0A,    // Arbitrary value
	parameter logic [3:0]  SILICON_REV    = 4'h3      // Arbitrary value
)(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic [4:0]  mgmt_dev_addr_i,
	input  wire logic [15:0] mgmt_reg_addr_i,
	input  wire logic        mgmt_wr_i,
	input  wire logic        mgmt_rd_i,
	input  wire logic [15:0] mgmt_wdata_i,
	input  wire logic [4:0]  led_function_select_i,
	input  wire logic        led_lower_level_i,
	input  wire logic        led_sensed_active_high_i,
	input  wire logic        blink_i,
	input  wire logic        high_transmit_level_i,
	input  wire logic        leader_i,
	input  wire logic        follower_i,
	input  wire logic        link_config_mismatch_i,
	input  wire logic        negotiated_link_good_i,
	input  wire logic        negotiation_done_i,
	input  wire logic        timestamp_timer_i,
	input  wire logic        local_receiver_ok_i,
	input  wire logic        remote_receiver_ok_i,
	input  wire logic        reference_clock_out_i,
	input  wire logic        transmit_clock_out_i,
	input  wire logic        internal_fast_clock_out_i,
	output logic [15:0]      mgmt_rdata_o,
	output logic             mgmt_rvalid_o,
	output logic             mgmt_hit_o,
	output logic [1:0]       led_drive_sense_select_o,
	output logic             led_o
);

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	logic        sel_sense;
	logic        sel_id_high;
	logic        sel_id_low;
	logic        sel_pres_lo;
	logic        sel_pres_hi;
	logic        sel_status;
	logic        led_mmd;
	logic        vnd_mmd;

	assign led_mmd     = (mgmt_dev_addr_i == led_mmd_id_pkg::LED_MMD_ADDR);
	assign vnd_mmd     = (mgmt_dev_addr_i == led_mmd_id_pkg::VENDOR_MMD_ADDR);
	assign sel_sense   = led_mmd
		&& (mgmt_reg_addr_i == led_mmd_id_pkg::LED_DRIVE_SENSE_ADDR);
	assign sel_id_high = vnd_mmd
		&& (mgmt_reg_addr_i == led_mmd_id_pkg::VENDOR_DEV_ID_HIGH_ADDR);
	assign sel_id_low  = vnd_mmd
		&& (mgmt_reg_addr_i == led_mmd_id_pkg::VENDOR_DEV_ID_LOW_ADDR);
	assign sel_pres_lo = vnd_mmd
		&& (mgmt_reg_addr_i == led_mmd_id_pkg::DEVICES_PRESENT_LO_ADDR);
	assign sel_pres_hi = vnd_mmd
		&& (mgmt_reg_addr_i == led_mmd_id_pkg::DEVICES_PRESENT_HI_ADDR);
	assign sel_status  = vnd_mmd
		&& (mgmt_reg_addr_i == led_mmd_id_pkg::VENDOR_DEV_STATUS_ADDR);

	// ------------------------------------------------------------
	// Drive sense register
	// ------------------------------------------------------------
	logic [1:0]  led_drive_sense_reg;

	// Only the sense register takes writes; all others drop them
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			led_drive_sense_reg <= led_mmd_id_pkg::LED_DRIVE_SENSE_RESET[1:0];
		else if (mgmt_wr_i && sel_sense)
			led_drive_sense_reg <= mgmt_wdata_i[1:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			led_drive_sense_select_o <= led_mmd_id_pkg::LED_DRIVE_SENSE_RESET[1:0];
		else
			led_drive_sense_select_o <= led_drive_sense_reg;
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic [15:0] id_low_val;
	logic [15:0] rdata_next;
	logic        hit_next;

	assign id_low_val = (16'(ORG_ID_BITS) << led_mmd_id_pkg::ORG_ID_LSB)
		| (16'(MODEL_NUMBER) << led_mmd_id_pkg::MODEL_LSB)
		| (16'(SILICON_REV) << led_mmd_id_pkg::REVISION_LSB);

	always_comb
	begin
		rdata_next = led_mmd_id_pkg::UNMAPPED_READ_VAL;
		hit_next   = 1'b1;
		if (sel_sense)
			rdata_next = {{(16 - led_mmd_id_pkg::SENSE_SELECT_W){1'b0}},
				led_drive_sense_reg};
		else if (sel_id_high)
			rdata_next = VENDOR_ID_HIGH;
		else if (sel_id_low)
			rdata_next = id_low_val;
		else if (sel_pres_lo)
			rdata_next = led_mmd_id_pkg::DEVICES_PRESENT_LO_VAL;
		else if (sel_pres_hi)
			rdata_next = led_mmd_id_pkg::DEVICES_PRESENT_HI_VAL;
		else if (sel_status)
			rdata_next = led_mmd_id_pkg::VENDOR_DEV_STATUS_VAL;
		else
			hit_next = 1'b0;
	end

	// Answer one cycle after the read strobe; unmapped reads give zero
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			mgmt_rdata_o  <= 16'h0000;
			mgmt_rvalid_o <= 1'b0;
			mgmt_hit_o    <= 1'b0;
		end
		else
		begin
			mgmt_rvalid_o <= mgmt_rd_i;
			if (mgmt_rd_i)
			begin
				mgmt_rdata_o <= rdata_next;
				mgmt_hit_o   <= hit_next;
			end
		end
	end

	// ------------------------------------------------------------
	// LED function decode
	// ------------------------------------------------------------
	logic        led_level;
	logic        active_high;

	// No link qualification: every code follows its signal directly
	always_comb
	begin
		unique case (led_function_select_i)
			led_mmd_id_pkg::FN_BLINK:             led_level = blink_i;
			led_mmd_id_pkg::FN_HIGH_TX_LEVEL:     led_level = high_transmit_level_i;
			led_mmd_id_pkg::FN_LOW_TX_LEVEL:      led_level = ~high_transmit_level_i;
			led_mmd_id_pkg::FN_LEADER:            led_level = leader_i;
			led_mmd_id_pkg::FN_FOLLOWER:          led_level = follower_i;
			led_mmd_id_pkg::FN_LINK_CFG_MISMATCH: led_level = link_config_mismatch_i;
			led_mmd_id_pkg::FN_LINK_GOOD:         led_level = negotiated_link_good_i;
			led_mmd_id_pkg::FN_NEGOTIATION_DONE:  led_level = negotiation_done_i;
			led_mmd_id_pkg::FN_TIMESTAMP_TIMER:   led_level = timestamp_timer_i;
			led_mmd_id_pkg::FN_LOCAL_RX_OK:       led_level = local_receiver_ok_i;
			led_mmd_id_pkg::FN_REMOTE_RX_OK:      led_level = remote_receiver_ok_i;
			led_mmd_id_pkg::FN_REF_CLOCK:         led_level = reference_clock_out_i;
			led_mmd_id_pkg::FN_TX_CLOCK:          led_level = transmit_clock_out_i;
			led_mmd_id_pkg::FN_FAST_CLOCK:        led_level = internal_fast_clock_out_i;
			// Codes below 15 come from the activity controller; 29 to 31 too
			default:                              led_level = led_lower_level_i;
		endcase
	end

	// Value 3 is reserved and falls back to the sensed polarity
	always_comb
	begin
		unique case (led_drive_sense_reg)
			led_mmd_id_pkg::SENSE_ACTIVE_HIGH: active_high = 1'b1;
			led_mmd_id_pkg::SENSE_ACTIVE_LOW:  active_high = 1'b0;
			default:                           active_high = led_sensed_active_high_i;
		endcase
	end

	// Clock codes are sampled at 100 MHz, so the fast clock aliases
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			led_o <= 1'b0;
		else
			led_o <= active_high ? led_level : ~led_level;
	end

endmodule

`default_nettype wire

// [led_mmd_id_regs_props.sv]
// Checker of the LED sense and vendor identifier registers
`timescale 1ns/1ps
`default_nettype none
module led_mmd_id_regs_props #(
	parameter logic [15:0] VENDOR_ID_HIGH = 16'h5A5A, // Arbitrary
	parameter logic [5:0]  ORG_ID_BITS    = 6'h15,    // Arbitrary
	parameter logic [5:0]  MODEL_NUMBER   = 6'h0A,    // Arbitrary
	parameter logic [3:0]  SILICON_REV    = 4'h3      // Arbitrary
)(
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic [4:0]  mgmt_dev_addr_i,
	input wire logic [15:0] mgmt_reg_addr_i,
	input wire logic        mgmt_wr_i,
	input wire logic        mgmt_rd_i,
	input wire logic [15:0] mgmt_wdata_i,
	input wire logic [4:0]  led_function_select_i,
	input wire logic        led_sensed_active_high_i,
	input wire logic        high_transmit_level_i,
	input wire logic        negotiated_link_good_i,
	input wire logic        transmit_clock_out_i,
	input wire logic [15:0] mgmt_rdata_o,
	input wire logic        mgmt_rvalid_o,
	input wire logic        mgmt_hit_o,
	input wire logic [1:0]  led_drive_sense_select_o,
	input wire logic        led_o
);
	logic       vrd;
	logic       swr;
	logic       wr_q;
	logic [1:0] sel_q;
	logic       calm;
	assign vrd = mgmt_rd_i && mgmt_dev_addr_i == 5'h1F;
	assign swr = mgmt_wr_i && mgmt_dev_addr_i == 5'h1E && mgmt_reg_addr_i == 16'h8C83;
	always_ff @(posedge clk_i)
	begin
		wr_q  <= mgmt_wr_i;
		sel_q <= led_drive_sense_select_o;
	end
	// Sense settled, no write in flight: led_o then sees one setting only
	assign calm = !mgmt_wr_i && !wr_q && led_drive_sense_select_o == sel_q;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_read_answer_next:
	assert property (mgmt_rvalid_o == $past(mgmt_rd_i)) else $error("read answer late");
	a_id_regs_fixed:
	assert property (vrd && mgmt_reg_addr_i[15:1] == 15'h1 |=> mgmt_hit_o && mgmt_rdata_o ==
		($past(mgmt_reg_addr_i[0]) ? {ORG_ID_BITS, MODEL_NUMBER, SILICON_REV} : VENDOR_ID_HIGH))
		else $error("identifier read wrong");
	a_const_regs_read:
	assert property (vrd && mgmt_reg_addr_i inside {16'h0005, 16'h0006, 16'h0008} |=> mgmt_hit_o
		&& mgmt_rdata_o == ($past(mgmt_reg_addr_i[3]) ? 16'h8000
		: $past(mgmt_reg_addr_i[0]) ? 16'h008B : 16'hC000)) else $error("constant read wrong");
	a_sense_readback:
	assert property (mgmt_rd_i && mgmt_dev_addr_i == 5'h1E && mgmt_reg_addr_i == 16'h8C83
		|=> mgmt_hit_o && mgmt_rdata_o == {14'h0, led_drive_sense_select_o})
		else $error("sense readback wrong");
	a_sense_write_lands:
	assert property (swr ##1 !mgmt_wr_i |=> led_drive_sense_select_o == $past(mgmt_wdata_i[1:0], 2))
		else $error("sense write lost");
	a_led_forced_high:
	assert property (calm && led_drive_sense_select_o == 2'h1 && led_function_select_i == 5'h15
		|=> led_o == $past(negotiated_link_good_i)) else $error("forced high wrong");
	a_led_forced_low:
	assert property (calm && led_drive_sense_select_o == 2'h2 && led_function_select_i == 5'h11
		|=> led_o == $past(high_transmit_level_i)) else $error("forced low wrong");
	a_clock_follows:
	assert property (calm && led_drive_sense_select_o == 2'h1 && led_function_select_i == 5'h1B
		|=> led_o == $past(transmit_clock_out_i)) else $error("clock route wrong");
	a_auto_sense_used:
	assert property (calm && led_drive_sense_select_o[0] == led_drive_sense_select_o[1]
		&& led_function_select_i == 5'h15 |=> led_o ==
		($past(led_sensed_active_high_i) ~^ $past(negotiated_link_good_i)))
		else $error("autosense wrong");
endmodule
bind led_mmd_id_regs led_mmd_id_regs_props #(.VENDOR_ID_HIGH(VENDOR_ID_HIGH),
	.ORG_ID_BITS(ORG_ID_BITS), .MODEL_NUMBER(MODEL_NUMBER), .SILICON_REV(SILICON_REV))
	led_mmd_id_regs_props_inst (.*);
`default_nettype wire

// [mgmt_host_model.sv]
// Management host model for the register port
`timescale 1ns/1ps
`default_nettype none
module mgmt_host_model (
	input wire logic        clk_i,
	input wire logic [15:0] mgmt_rdata_o,
	input wire logic        mgmt_rvalid_o,
	input wire logic        mgmt_hit_o,
	output logic [4:0]      mgmt_dev_addr_i,
	output logic [15:0]     mgmt_reg_addr_i,
	output logic            mgmt_wr_i,
	output logic            mgmt_rd_i,
	output logic [15:0]     mgmt_wdata_i
);
	logic [15:0] data;
	logic        hit;
	logic        got;
	logic        responding;
	task automatic put(input logic rd, input logic wr, input logic [4:0] dev,
		input logic [15:0] addr, input logic [15:0] wd);
		mgmt_rd_i       <= rd;
		mgmt_wr_i       <= wr;
		mgmt_dev_addr_i <= dev;
		mgmt_reg_addr_i <= addr;
		mgmt_wdata_i    <= wd;
	endtask
	initial put(1'b0, 1'b0, 5'h0, 16'h0, 16'h0);
	// Released lines show the inverse, so a stale address is never mistaken for a live one
	task automatic xfer(input logic rd, input logic [4:0] dev, input logic [15:0] addr, wd);
		int n;
		n = 0;
		got = 1'b0;
		@(posedge clk_i);
		put(rd, !rd, dev, addr, wd);
		@(posedge clk_i);
		put(1'b0, 1'b0, ~dev, ~addr, ~wd);
		// Sample on the falling edge, away from the edge that launches the answer
		while (rd && !got && n < 4)
		begin
			@(negedge clk_i);
			got = mgmt_rvalid_o === 1'b1;
			data = mgmt_rdata_o;
			hit = mgmt_hit_o;
			n++;
		end
		responding = data[15:14] === 2'b10;
	endtask
endmodule
`default_nettype wire

// [test_phy_led_and_vendor_mmd_id_regs.sv]
// Self-checking testbench of the LED sense and vendor identifier registers
`timescale 1ns/1ps
`default_nettype none
module test_phy_led_and_vendor_mmd_id_regs;
	localparam logic [15:0] ID_HI = 16'h1234; // Arbitrary
	localparam logic [15:0] ID_LO = 16'hA916; // Arbitrary fields 2A, 11, 6
	logic clk_i = 1'b0;
	logic reset_i, led_lower_level_i, led_sensed_active_high_i, mgmt_wr_i, mgmt_rd_i;
	logic mgmt_rvalid_o, mgmt_hit_o, led_o;
	logic [4:0] led_function_select_i, mgmt_dev_addr_i;
	logic [13:0] src;
	logic [15:0] mgmt_reg_addr_i, mgmt_wdata_i, mgmt_rdata_o;
	logic [1:0] led_drive_sense_select_o;
	int error_cnt = 0;
	int tests_run = 0;
	int i;
	logic [37:0] rows [9] = '{{5'h1F, 16'h0002, ID_HI, 1'b1}, {5'h1F, 16'h0003, ID_LO, 1'b1},
		{5'h1F, 16'h0005, 16'h008B, 1'b1}, {5'h1F, 16'h0006, 16'hC000, 1'b1},
		{5'h1F, 16'h0008, 16'h8000, 1'b1}, {5'h1E, 16'h8C83, 16'h0000, 1'b1},
		{5'h1F, 16'h0004, 16'h0000, 1'b0}, {5'h1E, 16'h0002, 16'h0000, 1'b0},
		{5'h1F, 16'h8C83, 16'h0000, 1'b0}};
	always #5 clk_i = ~clk_i;
	led_mmd_id_regs #(.VENDOR_ID_HIGH(ID_HI), .ORG_ID_BITS(6'h2A), .MODEL_NUMBER(6'h11),
		.SILICON_REV(4'h6)) led_mmd_id_regs_inst (.blink_i(src[0]), .high_transmit_level_i(src[1]),
		.leader_i(src[3]), .follower_i(src[4]), .link_config_mismatch_i(src[5]),
		.negotiated_link_good_i(src[6]), .negotiation_done_i(src[7]), .timestamp_timer_i(src[8]),
		.local_receiver_ok_i(src[9]), .remote_receiver_ok_i(src[10]),
		.reference_clock_out_i(src[11]), .transmit_clock_out_i(src[12]),
		.internal_fast_clock_out_i(src[13]), .*);
	mgmt_host_model mgmt_host_model_inst (.*);
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic rd(input logic [4:0] dev, input logic [15:0] adr, input logic [15:0] exp, input logic ht);
		mgmt_host_model_inst.xfer(1'b1, dev, adr, 16'h0);
		if (!mgmt_host_model_inst.got)
		begin
			error_cnt++;
			end_of_test();
		end
		else
		begin
			chk("rdata", mgmt_host_model_inst.data, exp);
			chk("hit", {15'h0, mgmt_host_model_inst.hit}, {15'h0, ht});
		end
	endtask
	// Three edges, as a new sense setting reaches the pin two edges after its write
	task automatic led(input logic [4:0] fn, input logic [13:0] s, input logic exp);
		led_function_select_i <= fn;
		src <= s;
		repeat (3) @(posedge clk_i);
		chk("led", {15'h0, led_o}, {15'h0, exp});
	endtask
	initial
	begin
		reset_i = 1'b1;
		led_function_select_i = 5'h15;
		led_lower_level_i = 1'b0;
		led_sensed_active_high_i = 1'b1;
		src = 14'h0;
		repeat (6) @(posedge clk_i);
		chk("sense", {14'h0, led_drive_sense_select_o}, 16'h0);
		reset_i <= 1'b0;
		mgmt_host_model_inst.xfer(1'b0, 5'h1F, 16'h0008, 16'hFFFF);
		mgmt_host_model_inst.xfer(1'b0, 5'h1F, 16'h0002, 16'h0000);
		for (i = 0; i < 9; i++)
			rd(rows[i][37:33], rows[i][32:17], rows[i][16:1], rows[i][0]);
		chk("responding", {15'h0, mgmt_host_model_inst.responding}, 16'h0);
		rd(5'h1F, 16'h0008, 16'h8000, 1'b1);
		chk("responding", {15'h0, mgmt_host_model_inst.responding}, 16'h1);
		$display("test register table done");
		mgmt_host_model_inst.xfer(1'b0, 5'h1E, 16'h8C83, 16'hFFFF);
		rd(5'h1E, 16'h8C83, 16'h0003, 1'b1);
		led_sensed_active_high_i <= 1'b0;
		led(5'h15, 14'h0040, 1'b0);
		led_sensed_active_high_i <= 1'b1;
		led(5'h15, 14'h0040, 1'b1);
		mgmt_host_model_inst.xfer(1'b0, 5'h1E, 16'h8C83, 16'h0001);
		for (i = 15; i < 29; i++)
		begin
			led(i[4:0], 14'h1 << (i - 15), 1'b1);
			led(i[4:0], ~(14'h1 << (i - 15)), 1'b0);
		end
		led(5'h05, 14'h3FFF, 1'b0);
		mgmt_host_model_inst.xfer(1'b0, 5'h1E, 16'h8C83, 16'h0002);
		led(5'h11, 14'h0002, 1'b1);
		led(5'h15, 14'h0040, 1'b0);
		$display("test led decode done");
		reset_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(5'h1E, 16'h8C83, 16'h0000, 1'b1);
		$display("test second reset done");
		end_of_test();
	end
endmodule
`default_nettype wire
